// File: hdl/afe_ctrl.sv
/*
  Top of the video front end control: AHB-Lite registers, strobe
  synchronisers, clamp switch steering, channel power-down, the three
  processing channels, conversion sequencing and the pixel output bus.
  Assumes strobes come from an outside timing generator and that a pixel
  period spans at least as many system clocks as there are channels.
*/
// Added by the designer: register access over AHB-Lite and the placing of the registers.
// Overview of operation
// - Output bus floats on enable pin or disable.
// - Width select resets to sixteen bits.
// - Width field picks sixteen, twelve, ten, eight.
// - Colour mode converts all three per pixel.
// - Two-channel mode powers down unused channel.
// - Mono mode powers down the two others.
// - Clamp closes only when enabled; enable resets one.
// - One clamp signal drives every channel.
// - Mode zero clamps while reference strobe high.
// - Mode one clamps when both strobes high; held open under double sampling.
// - Double sampling resets on; uses reset level.
// - Video level taken on video strobe fall.
// - Reset level taken on reference strobe fall.
// - Single sampling takes reference pin with video.
// - Per-channel offset then gain codes.
// - Black select ten gives FFFF at zero.
// - Black select eleven gives 0000 at zero.
// - Black select zero or one gives 7FFF.
// - Sixteen-bit word, optionally inverted.
// - Reference from pin or internal DAC.
`timescale 1ns/100ps
module afe_ctrl #(
  parameter int OUT_PINS = 12
) (
  // Clock and reset.
  input  wire logic                       I_CLK_SYS,
  input  wire logic                       I_SRST,
  // AHB-Lite slave.
  input  wire logic                       I_HSEL,
  input  wire logic [31:0]                I_HADDR,
  input  wire logic [1:0]                 I_HTRANS,
  input  wire logic                       I_HWRITE,
  input  wire logic [2:0]                 I_HSIZE,
  input  wire logic [31:0]                I_HWDATA,
  input  wire logic                       I_HREADY,
  output logic [31:0]                     O_HRDATA,
  output logic                            O_HREADYOUT,
  output logic                            O_HRESP,
  // Sensor side pins.
  input  wire logic                       I_OUTPUT_ENABLE_N_PIN,
  input  wire logic                       I_VIDEO_SAMPLE_STROBE,
  input  wire logic                       I_REFERENCE_SAMPLE_STROBE,
  input  wire logic [afe_pkg::WORD_W-1:0] I_RED_INPUT,
  input  wire logic [afe_pkg::WORD_W-1:0] I_GREEN_INPUT,
  input  wire logic [afe_pkg::WORD_W-1:0] I_BLUE_INPUT,
  input  wire logic [afe_pkg::WORD_W-1:0] I_REFERENCE_LEVEL_PIN,
  // Pixel output.
  output logic [OUT_PINS-1:0]             O_PIXEL_OUTPUT_BUS,
  output logic                            O_PIXEL_OUTPUT_BUS_OE,
  output logic [afe_pkg::WORD_W-1:0]      O_PIXEL_WORD,
  output logic                            O_PIXEL_VALID,
  output logic [1:0]                      O_PIXEL_CHAN,
  // Analogue controls.
  output logic                            O_CLAMP_SWITCH_CONTROL,
  output logic [afe_pkg::NUM_CH-1:0]      O_CHAN_POWERDOWN,
  output logic                            O_INPUT_BUFFER_ENABLE,
  output logic                            O_REFERENCE_DAC_POWERDOWN
);
  import afe_pkg::*;

  if (OUT_PINS < 1 || OUT_PINS > WORD_W) begin : g_chk
    $error("OUT_PINS must lie between 1 and the word width");
  end

  localparam int SYNC_W = 3 + 4 * WORD_W;

  ctrl_t        ctrl_reg;                  // Control word.
  chan_cfg_t    chan_reg [NUM_CH];         // Offset and gain per channel.
  bus_state_t   bus_state;                 // Read wait tracking.
  logic         wr_pend_reg;               // Write data phase pending.
  logic [7:0]   wr_addr_reg;               // Address of that write.
  logic [7:0]   rd_addr_reg;               // Address of pending read.
  logic [31:0]  rd_word;                   // Read mux output.
  logic         acc;                       // Address phase taken.
  logic [SYNC_W-1:0] sync_q;               // Synchronised pins.
  logic         oeb_s;                     // Enable pin, active low.
  logic         vs_s;                      // Video strobe.
  logic         rs_s;                      // Reference strobe.
  logic [15:0]  lvl_s [NUM_CH];            // Input levels.
  logic [15:0]  pin_s;                     // Reference pin level.
  logic         vs_d_reg;                  // Delayed video strobe.
  logic         rs_d_reg;                  // Delayed reference strobe.
  logic         vs_fall;
  logic         rs_fall;
  logic [15:0]  code [NUM_CH];             // Channel results.
  logic [NUM_CH-1:0] done;                 // Channel result strobes.
  logic [NUM_CH-1:0] pend_reg;             // Conversions waiting.
  logic [NUM_CH-1:0] pick_mask;
  logic [1:0]   pick_idx;
  logic [NUM_CH-1:0] sel_hot;              // Selected channel, one-hot.
  logic [NUM_CH-1:0] pd_next;
  logic         clamp_next;
  logic [15:0]  word_next;
  proc_cfg_t    proc;

  // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
  assign acc = I_HSEL && I_HTRANS[1] && I_HREADY;

  // Address phase capture and read wait; reads get one wait state so that
  // a write in the cycle before is always visible to them.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      bus_state   <= BUS_IDLE;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      O_HREADYOUT <= 1'b1;
      O_HRDATA    <= 32'h0000_0000;
      O_HRESP     <= 1'b0;
    end else begin
      O_HRESP     <= 1'b0;
      wr_pend_reg <= acc && I_HWRITE && (I_HSIZE == HSIZE_WORD);
      if (acc) begin
        wr_addr_reg <= I_HADDR[7:0];
      end
      case (bus_state)
        BUS_IDLE: begin
          if (acc && !I_HWRITE) begin
            rd_addr_reg <= I_HADDR[7:0];
            O_HREADYOUT <= 1'b0;
            bus_state   <= BUS_RD_WAIT;
          end
        end
        BUS_RD_WAIT: begin
          O_HRDATA    <= rd_word;
          O_HREADYOUT <= 1'b1;
          bus_state   <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Unmapped addresses read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_addr_reg == CTRL_OFS) begin
      rd_word = ctrl_reg;
    end else if (rd_addr_reg == STATUS_OFS) begin
      rd_word = {24'h00_0000, pend_reg, O_CLAMP_SWITCH_CONTROL,
                 O_PIXEL_OUTPUT_BUS_OE, O_CHAN_POWERDOWN};
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (rd_addr_reg == CHAN_OFS + 8'(4 * i)) begin
        rd_word = chan_reg[i];
      end
    end
  end

  // Register writes commit at the end of their data phase.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      ctrl_reg <= ctrl_t'(CTRL_RESET);
      for (int i = 0; i < NUM_CH; i++) begin
        chan_reg[i] <= chan_cfg_t'(CHAN_RESET);
      end
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == CTRL_OFS) begin
        ctrl_reg <= ctrl_t'(I_HWDATA & CTRL_MASK);
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_addr_reg == CHAN_OFS + 8'(4 * i)) begin
          chan_reg[i] <= chan_cfg_t'(I_HWDATA & CHAN_MASK);
        end
      end
    end
  end

  // All pins pass two flops; strobes and levels stay aligned.
  afe_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk  (I_CLK_SYS),
    .i_srst (I_SRST),
    .i_d    ({I_OUTPUT_ENABLE_N_PIN, I_VIDEO_SAMPLE_STROBE,
              I_REFERENCE_SAMPLE_STROBE, I_RED_INPUT, I_GREEN_INPUT,
              I_BLUE_INPUT, I_REFERENCE_LEVEL_PIN}),
    .o_q    (sync_q)
  );
  assign {oeb_s, vs_s, rs_s, lvl_s[0], lvl_s[1], lvl_s[2], pin_s} = sync_q;

  // Falling edges of the synchronised strobes.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      vs_d_reg <= 1'b0;
      rs_d_reg <= 1'b0;
    end else begin
      vs_d_reg <= vs_s;
      rs_d_reg <= rs_s;
    end
  end
  assign vs_fall = vs_d_reg && !vs_s;
  assign rs_fall = rs_d_reg && !rs_s;

  assign proc = '{double_sampling_select: ctrl_reg.double_sampling_select, dac_pd: ctrl_reg.dac_pd,
                  dac_code: ctrl_reg.dac_code,
                  black_sel: ctrl_reg.black_sel};

  // One channel per input; power-down stops its sampling.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    afe_channel u_ch (
      .i_clk     (I_CLK_SYS),
      .i_srst    (I_SRST),
      .i_vs_fall (vs_fall),
      .i_rs_fall (rs_fall),
      .i_enable  (!O_CHAN_POWERDOWN[g]),
      .i_video   (lvl_s[g]),
      .i_ref_pin (pin_s),
      .i_cfg     (chan_reg[g]),
      .i_proc    (proc),
      .o_code    (code[g]),
      .o_done    (done[g])
    );
  end

  // Channel select decode; codes above the last channel mean red.
  always_comb begin
    case (ctrl_reg.chan_select)
      2'h1:    sel_hot = 3'b010;
      2'h2:    sel_hot = 3'b100;
      default: sel_hot = 3'b001;
    endcase
    case (ctrl_reg.chan_mode)
      MODE_TWO:  pd_next = sel_hot;
      MODE_MONO: pd_next = ~sel_hot;
      default:   pd_next = 3'b000;
    endcase
  end

  // Clamp steering; mode one is held open under double sampling.
  always_comb begin
    if (!ctrl_reg.clamp_en) begin
      clamp_next = 1'b0;
    end else if (!ctrl_reg.clamp_mode) begin
      clamp_next = rs_s;
    end else begin
      clamp_next = vs_s && rs_s && !ctrl_reg.double_sampling_select;
    end
  end

  // Analogue controls; a single clamp line serves all channels.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_CLAMP_SWITCH_CONTROL    <= 1'b0;
      O_CHAN_POWERDOWN          <= 3'b000;
      O_INPUT_BUFFER_ENABLE     <= 1'b0;
      O_REFERENCE_DAC_POWERDOWN <= 1'b0;
    end else begin
      O_CLAMP_SWITCH_CONTROL    <= clamp_next;
      O_CHAN_POWERDOWN          <= pd_next;
      // Software sets this for line clamping without double sampling.
      O_INPUT_BUFFER_ENABLE     <= ctrl_reg.in_buf_en;
      O_REFERENCE_DAC_POWERDOWN <= ctrl_reg.dac_pd;
    end
  end

  // Lowest waiting channel is converted first.
  always_comb begin
    pick_idx = 2'd0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick_idx = 2'(i);
      end
    end
    pick_mask = 3'b001 << pick_idx;
  end

  // New results win over the clear of the one just converted.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      pend_reg <= 3'b000;
    end else begin
      pend_reg <= (pend_reg & ~pick_mask) | done;
    end
  end

  // Invert first, then keep only the top bits of the chosen width.
  always_comb begin
    word_next = ctrl_reg.invert ? ~code[pick_idx] : code[pick_idx];
    case (ctrl_reg.width)
      WIDTH_12: word_next = word_next & 16'hFFF0;
      WIDTH_10: word_next = word_next & 16'hFFC0;
      WIDTH_8:  word_next = word_next & 16'hFF00;
      default:  word_next = word_next;
    endcase
  end

  // Output word and bus; the bus carries the top bits of the word.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_PIXEL_WORD          <= 16'h0000;
      O_PIXEL_OUTPUT_BUS    <= '0;
      O_PIXEL_VALID         <= 1'b0;
      O_PIXEL_CHAN          <= 2'h0;
      O_PIXEL_OUTPUT_BUS_OE <= 1'b0;
    end else begin
      O_PIXEL_VALID         <= |pend_reg;
      O_PIXEL_OUTPUT_BUS_OE <= !oeb_s && !ctrl_reg.out_dis;
      if (|pend_reg) begin
        O_PIXEL_WORD       <= word_next;
        O_PIXEL_OUTPUT_BUS <= word_next[WORD_W-1 -: OUT_PINS];
        O_PIXEL_CHAN       <= pick_idx;
      end
    end
  end

  sequence three_conv_s;
    O_PIXEL_VALID [*3];
  endsequence

  sequence both_high_s;
    vs_s && rs_s;
  endsequence

  out_hiz_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (oeb_s || ctrl_reg.out_dis) |=> !O_PIXEL_OUTPUT_BUS_OE)
    else $error("output bus driven while disabled");
  width_rst_a: assert property (@(posedge I_CLK_SYS)
    $fell(I_SRST) |-> ctrl_reg.width == WIDTH_16 && ctrl_reg.clamp_en
                      && ctrl_reg.double_sampling_select)
    else $error("control word not at its reset value");
  width_eight_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SRST)
    O_PIXEL_VALID && $past(ctrl_reg.width) == WIDTH_8
    |-> O_PIXEL_WORD[7:0] == 8'h00)
    else $error("eight-bit word has low bits set");
  colour_conv_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SRST)
    done == 3'b111 && pend_reg == 3'b000 |-> ##2 three_conv_s)
    else $error("colour pixel not converted on three cycles");
  two_pd_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    ctrl_reg.chan_mode == MODE_TWO |=> $countones(O_CHAN_POWERDOWN) == 1)
    else $error("two-channel mode must power down one channel");
  mono_pd_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    ctrl_reg.chan_mode == MODE_MONO |=> $countones(O_CHAN_POWERDOWN) == 2)
    else $error("mono mode must power down two channels");
  clamp_off_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    !ctrl_reg.clamp_en |=> !O_CLAMP_SWITCH_CONTROL)
    else $error("clamp closed while disabled");
  clamp_rs_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    ctrl_reg.clamp_en && !ctrl_reg.clamp_mode
    |=> O_CLAMP_SWITCH_CONTROL == $past(rs_s))
    else $error("clamp does not follow reference strobe");
  clamp_both_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (ctrl_reg.clamp_en && ctrl_reg.clamp_mode && !ctrl_reg.double_sampling_select)
    and both_high_s |=> O_CLAMP_SWITCH_CONTROL)
    else $error("clamp open while both strobes high");
  clamp_one_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    ctrl_reg.clamp_mode && !(vs_s && rs_s) |=> !O_CLAMP_SWITCH_CONTROL)
    else $error("clamp closed outside both strobes");
  invert_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    |pend_reg && ctrl_reg.invert && ctrl_reg.width == WIDTH_16
    |=> O_PIXEL_WORD == ~$past(code[pick_idx]))
    else $error("inverted word wrong");
endmodule : afe_ctrl

// File: hdl/afe_pkg.sv
/*
  Shared constants, register layouts and types of the video front end.
  Assumes a 32-bit AHB-Lite register bus and 16-bit digitised levels.
*/
package afe_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CHAN_OFS   = 8'h08;

  // Data path sizes; a gain code of 64 is unity.
  localparam int WORD_W    = 16;
  localparam int NUM_CH    = 3;
  localparam int GAIN_FRAC = 6;
  localparam int DAC_SHIFT = 12;
  localparam logic [7:0] OFFSET_ZERO = 8'h80;

  // Channel mode codes.
  localparam logic [1:0] MODE_COLOUR = 2'h0;
  localparam logic [1:0] MODE_TWO    = 2'h1;
  localparam logic [1:0] MODE_MONO   = 2'h2;

  // Conversion width codes.
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_12 = 2'h1;
  localparam logic [1:0] WIDTH_10 = 2'h2;
  localparam logic [1:0] WIDTH_8  = 2'h3;

  // Black offset codes and the levels they place zero input at.
  localparam logic [1:0]  BLACK_TOP    = 2'h2;
  localparam logic [1:0]  BLACK_BOTTOM = 2'h3;
  localparam logic [15:0] LEVEL_TOP    = 16'hFFFF;
  localparam logic [15:0] LEVEL_MID    = 16'h7FFF;
  localparam logic [15:0] LEVEL_BOTTOM = 16'h0000;

  // Only whole-word writes are taken.
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Control word; reserved bits are held at zero.
  typedef struct packed {
    logic [12:0] rsvd;
    logic [3:0]  dac_code;
    logic [1:0]  chan_select;
    logic [1:0]  chan_mode;
    logic        dac_pd;
    logic        in_buf_en;
    logic        clamp_mode;
    logic        clamp_en;
    logic        double_sampling_select;
    logic [1:0]  black_sel;
    logic        invert;
    logic [1:0]  width;
    logic        out_dis;
  } ctrl_t;
  localparam logic [31:0] CTRL_RESET = 32'h0000_00C0;
  localparam logic [31:0] CTRL_MASK  = 32'h0007_FFFF;

  // Per-channel offset and gain word.
  typedef struct packed {
    logic [14:0] rsvd;
    logic [8:0]  gain;
    logic [7:0]  offset;
  } chan_cfg_t;
  localparam logic [31:0] CHAN_RESET = 32'h0000_4080;
  localparam logic [31:0] CHAN_MASK  = 32'h0001_FFFF;

  // Processing settings common to every channel.
  typedef struct packed {
    logic       double_sampling_select;
    logic       dac_pd;
    logic [3:0] dac_code;
    logic [1:0] black_sel;
  } proc_cfg_t;

  // Bus slave states.
  typedef enum logic {BUS_IDLE, BUS_RD_WAIT} bus_state_t;

endpackage : afe_pkg

// File: hdl/afe_sync.sv
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes multi-bit levels are stable around the strobe edges that use them.
*/
`timescale 1ns/100ps
module afe_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Levels in and out.
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  // The first stage feeds only the second stage.
  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_chk
    $error("afe_sync needs a width of at least one");
  end

  // Two stages on every edge.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule : afe_sync

// File: hdl/afe_channel.sv
/*
  One processing channel: sampling, referencing, offset, gain and
  black-level placement into a 16-bit unsigned word.
  Assumes strobe edge pulses and levels already share the system clock.
*/
`timescale 1ns/100ps
module afe_channel (
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  // Strobe edges and power.
  input  wire logic                       i_vs_fall,
  input  wire logic                       i_rs_fall,
  input  wire logic                       i_enable,
  // Input and reference levels.
  input  wire logic [afe_pkg::WORD_W-1:0] i_video,
  input  wire logic [afe_pkg::WORD_W-1:0] i_ref_pin,
  // Settings.
  input  wire afe_pkg::chan_cfg_t         i_cfg,
  input  wire afe_pkg::proc_cfg_t         i_proc,
  // Result.
  output logic [afe_pkg::WORD_W-1:0]      o_code,
  output logic                            o_done
);
  import afe_pkg::*;

  logic [15:0]        video_reg; // Video level sample.
  logic [15:0]        reset_reg; // Reset level sample.
  logic [15:0]        pin_reg;   // Reference pin sample.
  logic               cap_reg;   // A video sample was just taken.
  logic [15:0]        ref_lvl;   // Chosen reference.
  logic [15:0]        dac_lvl;   // Internal reference DAC level.
  logic [15:0]        base;      // Code for zero input.
  logic signed [16:0] diff;
  logic signed [17:0] v2;
  logic signed [27:0] v3;
  logic signed [27:0] sum;

  // Samples are taken only while the channel is powered.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      video_reg <= '0;
      pin_reg   <= '0;
      cap_reg   <= 1'b0;
    end else begin
      cap_reg <= i_vs_fall && i_enable;
      if (i_vs_fall && i_enable) begin
        video_reg <= i_video;
        pin_reg   <= i_ref_pin;
      end
    end
  end

  // The reset level is only needed with double sampling.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      reset_reg <= '0;
    end else if (i_rs_fall && i_enable && i_proc.double_sampling_select) begin
      reset_reg <= i_video;
    end
  end

  // Offset is added before the gain; the result is clipped to 16 bits.
  always_comb begin
    dac_lvl = 16'({12'h000, i_proc.dac_code} << DAC_SHIFT);
    if (i_proc.double_sampling_select) begin
      ref_lvl = reset_reg;
    end else begin
      ref_lvl = i_proc.dac_pd ? pin_reg : dac_lvl;
    end
    diff = $signed({1'b0, video_reg}) - $signed({1'b0, ref_lvl});
    v2 = 18'(diff) + 18'($signed({1'b0, i_cfg.offset}))
       - 18'($signed({1'b0, OFFSET_ZERO}));
    v3 = 28'(v2 * $signed({1'b0, i_cfg.gain})) >>> GAIN_FRAC;
    case (i_proc.black_sel)
      BLACK_TOP:    base = LEVEL_TOP;
      BLACK_BOTTOM: base = LEVEL_BOTTOM;
      default:      base = LEVEL_MID;
    endcase
    sum = $signed({12'h000, base}) + v3;
  end

  // The word is unsigned, so negative sums clip to zero.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_code <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= cap_reg;
      if (cap_reg) begin
        if (sum < 0) begin
          o_code <= 16'h0000;
        end else if (sum > 28'sh000_FFFF) begin
          o_code <= 16'hFFFF;
        end else begin
          o_code <= sum[15:0];
        end
      end
    end
  end

  video_cap_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_vs_fall && i_enable |=> video_reg == $past(i_video))
    else $error("video level not captured on strobe fall");
  reset_cap_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rs_fall && i_enable && i_proc.double_sampling_select |=> reset_reg == $past(i_video))
    else $error("reset level not captured");
endmodule : afe_channel

// File: tb/sensor_model.sv
/*
  Sensor timing generator model: one pixel per go pulse.
  Assumes go is one clock long and pixels are spaced by 30 clocks.
*/
`timescale 1ns/100ps
module sensor_model (
  // Clock and trigger.
  input  wire logic        i_clk,
  input  wire logic        i_go,
  // Levels to present.
  input  wire logic [15:0] i_level,
  input  wire logic [15:0] i_ref,
  input  wire logic        i_black, // Pixel is a black one.
  // Strobes and pins.
  output logic             o_vs,
  output logic             o_rs,
  output logic [15:0]      o_video,
  output logic [15:0]      o_ref_pin
);
  logic [3:0] step_reg = 4'h0; // Position in the pixel; zero is idle.
  // Step through one pixel, then rest at zero.
  always_ff @(posedge i_clk) begin
    step_reg <= i_go ? 4'h1 : (step_reg == 4'h0 ? 4'h0 : step_reg + 4'h1);
  end
  // The reference strobe joins the video strobe on black pixels only,
  // as line clamping asks of the sensor side.
  assign o_rs      = (step_reg == 4'h2) || (step_reg == 4'h3)
                     || (i_black && step_reg == 4'h7);
  assign o_vs      = (step_reg == 4'h6) || (step_reg == 4'h7);
  assign o_video   = i_level;
  assign o_ref_pin = i_ref;
endmodule : sensor_model

// File: tb/video_afe_sample_clamp_control_tb.sv
/*
  Bench for the front end control: bus tasks and pixel runs.
  Assumes the sensor model and the design package are compiled first.
*/
`timescale 1ns/100ps
module video_afe_sample_clamp_control_tb;
  import afe_pkg::*;
  logic        clk, rst, hsel, hwrite, oen, go, hrdy, oe, vld, clamp_switch_control, vs, rs;
  logic [1:0]  htrans, pch;
  logic        blk, hresp, ibuf, dpd;
  logic [31:0] haddr, hwdata, rdat, rd;
  logic [15:0] level, refl, vid, refp, word;
  logic [11:0] bus;
  logic [2:0]  pd;
  int          fails = 0, cmp_count = 0;
  ctrl_t       c;
  logic [15:0] lv [4] = '{LEVEL_MID, LEVEL_MID, LEVEL_TOP, LEVEL_BOTTOM};
  logic [15:0] wm [4] = '{16'hFFFF, 16'hFFF0, 16'hFFC0, 16'hFF00};
  sensor_model u_sensor_model (.i_clk(clk), .i_go(go), .i_level(level),
    .i_ref(refl), .i_black(blk), .o_vs(vs), .o_rs(rs), .o_video(vid),
    .o_ref_pin(refp));
  afe_ctrl u_afe_ctrl (.I_CLK_SYS(clk), .I_SRST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(HSIZE_WORD), .I_HWDATA(hwdata), .I_HREADY(hrdy),
    .O_HRDATA(rdat), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
    .I_OUTPUT_ENABLE_N_PIN(oen), .I_VIDEO_SAMPLE_STROBE(vs),
    .I_REFERENCE_SAMPLE_STROBE(rs), .I_RED_INPUT(vid), .I_GREEN_INPUT(vid),
    .I_BLUE_INPUT(vid), .I_REFERENCE_LEVEL_PIN(refp),
    .O_PIXEL_OUTPUT_BUS(bus), .O_PIXEL_OUTPUT_BUS_OE(oe), .O_PIXEL_WORD(word),
    .O_PIXEL_VALID(vld), .O_PIXEL_CHAN(pch), .O_CLAMP_SWITCH_CONTROL(clamp_switch_control),
    .O_CHAN_POWERDOWN(pd), .O_INPUT_BUFFER_ENABLE(ibuf),
    .O_REFERENCE_DAC_POWERDOWN(dpd));
  // Compare one result and count it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Print the verdict and stop.
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Wait, bounded, for ready sampled high at a rising edge.
  task automatic wt;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask : wt
  // One single word transfer; read data lands in rd.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = rdat;
  endtask : xfer
  // One pixel: count conversions, check words and whether clamp closed.
  task automatic pixel(input int n, input logic [15:0] e, input logic cl);
    int k;
    logic s;
    k = 0;
    s = 1'b0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      s = s | (clamp_switch_control === 1'b1);
      if (vld === 1'b1) begin
        k++;
        chk(32'(word), 32'(e));
        chk(32'(bus), 32'(e[15:4]));
      end
    end
    chk(32'(k), 32'(n));
    chk(32'(s), 32'(cl));
  endtask : pixel
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence.
  initial begin
    {rst, hsel, hwrite, oen, go, blk} = 6'h20;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    level = 16'h3000;
    refl = 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, CTRL_RESET);
    xfer(1'b0, CHAN_OFS, 32'h0000_0000);
    chk(rd, CHAN_RESET);
    xfer(1'b1, CHAN_OFS + 8'h04, 32'h0001_FF80);
    xfer(1'b0, CHAN_OFS + 8'h04, 32'h0000_0000);
    chk(rd, 32'h0001_FF80);
    xfer(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
    xfer(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rd, CTRL_MASK);
    repeat (4) @(posedge clk);
    chk(32'(oe), 32'h0000_0000);
    for (int b = 0; b < 4; b++) begin
      c = CTRL_RESET;
      c.black_sel = 2'(b);
      xfer(1'b1, CTRL_OFS, c);
      pixel(3, lv[b], 1'b1);
    end
    chk(32'(oe), 32'h0000_0001);
    c.invert = 1'b1;
    xfer(1'b1, CTRL_OFS, c);
    pixel(3, 16'hFFFF, 1'b1);
    c = CTRL_RESET;
    for (int w = 0; w < 4; w++) begin
      c.width = 2'(w);
      xfer(1'b1, CTRL_OFS, c);
      pixel(3, LEVEL_MID & wm[w], 1'b1);
    end
    c = CTRL_RESET;
    c.chan_mode = MODE_MONO;
    c.chan_select = 2'h1;
    c.clamp_en = 1'b0;
    xfer(1'b1, CTRL_OFS, c);
    pixel(1, LEVEL_MID, 1'b0);
    chk(32'(pd), 32'h0000_0005);
    chk(32'(pch), 32'h0000_0001);
    xfer(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_000D);
    c.chan_mode = MODE_TWO;
    xfer(1'b1, CTRL_OFS, c);
    pixel(2, LEVEL_MID, 1'b0);
    chk(32'($countones(pd)), 32'h0000_0001);
    c = CTRL_RESET;
    c.double_sampling_select = 1'b0;
    c.dac_pd = 1'b1;
    c.in_buf_en = 1'b1;
    c.clamp_mode = 1'b1;
    refl <= level;
    blk <= 1'b1;
    xfer(1'b1, CTRL_OFS, c);
    pixel(3, LEVEL_MID, 1'b1);
    chk(32'({ibuf, dpd}), 32'h0000_0003);
    c.dac_pd = 1'b0;
    c.dac_code = 4'h3;
    refl <= 16'h0000;
    blk <= 1'b0;
    xfer(1'b1, CTRL_OFS, c);
    pixel(3, LEVEL_MID, 1'b0);
    oen <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(oe), 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    tally_and_finish();
  end
endmodule : video_afe_sample_clamp_control_tb
